// ==== hw/lpsc_pkg.sv ====
package lpsc_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h0d;
  localparam logic [7:0] ADDR_ANALOG_CONTROL = 8'h0f;
  localparam logic [7:0] ADDR_PART_IDENTITY = 8'h12;
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h13;
  localparam logic [7:0] ADDR_LIGHT0_LOW = 8'h14;
  localparam logic [7:0] ADDR_LIGHT0_HIGH = 8'h15;
  localparam logic [7:0] ADDR_LIGHT1_LOW = 8'h16;
  localparam logic [7:0] ADDR_LIGHT1_HIGH = 8'h17;
  localparam logic [7:0] ADDR_PROX_LOW = 8'h18;
  localparam logic [7:0] ADDR_PROX_HIGH = 8'h19;

  localparam int CTRL_DRIVE_LSB = 6;
  localparam int CTRL_DIODE_LSB = 4;
  localparam int CTRL_PROX_GAIN_SELECT_LSB = 2;
  localparam int CTRL_LIGHT_GAIN_SELECT_LSB = 0;
  localparam int CFG_REDUCED_DRIVE_BIT = 0;

  localparam int STAT_PROX_SAT_BIT = 6;
  localparam int STAT_PROX_IRQ_BIT = 5;
  localparam int STAT_LIGHT_IRQ_BIT = 4;
  localparam int STAT_PROX_VALID_BIT = 1;
  localparam int STAT_LIGHT_VALID_BIT = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [1:0] DIODE_CH1 = 2'h2;

  // LED current in 0.1 mA units, normal then reduced column
  localparam logic [10:0] DRIVE_NORMAL_0 = 11'h3e8;
  localparam logic [10:0] DRIVE_NORMAL_1 = 11'h1f4;
  localparam logic [10:0] DRIVE_NORMAL_2 = 11'h0fa;
  localparam logic [10:0] DRIVE_NORMAL_3 = 11'h07d;
  localparam logic [10:0] DRIVE_REDUCED_0 = 11'h06f;
  localparam logic [10:0] DRIVE_REDUCED_1 = 11'h038;
  localparam logic [10:0] DRIVE_REDUCED_2 = 11'h01c;
  localparam logic [10:0] DRIVE_REDUCED_3 = 11'h00e;

  localparam logic [3:0] PROX_GAIN_SELECT_X1 = 4'h1;
  localparam logic [3:0] PROX_GAIN_SELECT_X2 = 4'h2;
  localparam logic [3:0] PROX_GAIN_SELECT_X4 = 4'h4;
  localparam logic [3:0] PROX_GAIN_SELECT_X8 = 4'h8;
  localparam logic [6:0] LIGHT_GAIN_SELECT_X1 = 7'h01;
  localparam logic [6:0] LIGHT_GAIN_SELECT_X8 = 7'h08;
  localparam logic [6:0] LIGHT_GAIN_SELECT_X16 = 7'h10;
  localparam logic [6:0] LIGHT_GAIN_SELECT_X120 = 7'h78;

  // Arbitrary neutral identity value
  localparam logic [7:0] PART_IDENTITY_DEFAULT = 8'h5a;
endpackage : lpsc_pkg

// ==== hw/lpsc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpsc_regs #(
  parameter logic [7:0] PART_IDENTITY = lpsc_pkg::PART_IDENTITY_DEFAULT
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic [15:0] light0_result,
  input wire logic [15:0] light1_result,
  input wire logic [15:0] prox_result,
  input wire logic light0_done,
  input wire logic light1_done,
  input wire logic prox_done,
  input wire logic light_valid_clear,
  input wire logic prox_valid_clear,
  input wire logic prox_saturated,
  input wire logic prox_irq,
  input wire logic light_irq,
  output logic [1:0] led_drive_select,
  output logic [1:0] prox_diode_select,
  output logic [1:0] prox_gain_select,
  output logic [1:0] light_gain_select,
  output logic reduced_drive_bit,
  output logic [10:0] led_current_tenth_ma,
  output logic [3:0] prox_gain_mult,
  output logic [6:0] light_gain_mult,
  output logic prox_diode_legal
);

  function automatic logic [10:0] drive_current(input logic [1:0] code, input logic reduced);
    logic [10:0] val;
    val = lpsc_pkg::DRIVE_NORMAL_0;
    case ({reduced, code})
      3'h0: val = lpsc_pkg::DRIVE_NORMAL_0;
      3'h1: val = lpsc_pkg::DRIVE_NORMAL_1;
      3'h2: val = lpsc_pkg::DRIVE_NORMAL_2;
      3'h3: val = lpsc_pkg::DRIVE_NORMAL_3;
      3'h4: val = lpsc_pkg::DRIVE_REDUCED_0;
      3'h5: val = lpsc_pkg::DRIVE_REDUCED_1;
      3'h6: val = lpsc_pkg::DRIVE_REDUCED_2;
      default: val = lpsc_pkg::DRIVE_REDUCED_3;
    endcase
    return val;
  endfunction

  function automatic logic [3:0] prox_gain(input logic [1:0] code);
    logic [3:0] val;
    val = lpsc_pkg::PROX_GAIN_SELECT_X1;
    case (code)
      2'h0: val = lpsc_pkg::PROX_GAIN_SELECT_X1;
      2'h1: val = lpsc_pkg::PROX_GAIN_SELECT_X2;
      2'h2: val = lpsc_pkg::PROX_GAIN_SELECT_X4;
      default: val = lpsc_pkg::PROX_GAIN_SELECT_X8;
    endcase
    return val;
  endfunction

  function automatic logic [6:0] light_gain(input logic [1:0] code);
    logic [6:0] val;
    val = lpsc_pkg::LIGHT_GAIN_SELECT_X1;
    case (code)
      2'h0: val = lpsc_pkg::LIGHT_GAIN_SELECT_X1;
      2'h1: val = lpsc_pkg::LIGHT_GAIN_SELECT_X8;
      2'h2: val = lpsc_pkg::LIGHT_GAIN_SELECT_X16;
      default: val = lpsc_pkg::LIGHT_GAIN_SELECT_X120;
    endcase
    return val;
  endfunction

  logic rst_meta_q, rst_meta_d;
  logic rst_sync_q, rst_sync_d;
  // Internal reset asserts at once and releases two edges after resetn
  wire logic rst_n = rst_sync_q;

  always_comb begin
    rst_meta_d = 1'b1;
    rst_sync_d = rst_meta_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_sync_q <= rst_sync_d;
    end
  end

  logic [7:0] control_q, control_d;
  logic config_q, config_d;
  logic prox_valid_q, prox_valid_d;
  logic light0_seen_q, light0_seen_d;
  logic light1_seen_q, light1_seen_d;
  logic light_valid_q, light_valid_d;
  logic [7:0] shadow0_q, shadow0_d;
  logic [7:0] shadow1_q, shadow1_d;
  logic [7:0] shadowp_q, shadowp_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic [10:0] current_q, current_d;
  logic [3:0] prox_gain_select_q, prox_gain_select_d;
  logic [6:0] light_gain_select_q, light_gain_select_d;
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[lpsc_pkg::STAT_PROX_SAT_BIT] = prox_saturated;
    status_byte[lpsc_pkg::STAT_PROX_IRQ_BIT] = prox_irq;
    status_byte[lpsc_pkg::STAT_LIGHT_IRQ_BIT] = light_irq;
    status_byte[lpsc_pkg::STAT_PROX_VALID_BIT] = prox_valid_q;
    status_byte[lpsc_pkg::STAT_LIGHT_VALID_BIT] = light_valid_q;
  end

  always_comb begin
    control_d = control_q;
    config_d = config_q;
    if (reg_wr_en) begin
      if (reg_addr == lpsc_pkg::ADDR_ANALOG_CONTROL) begin
        control_d = reg_wr_data;
      end else if (reg_addr == lpsc_pkg::ADDR_CONFIG) begin
        config_d = reg_wr_data[lpsc_pkg::CFG_REDUCED_DRIVE_BIT];
      end
    end
    // Identity, status and results ignore writes
  end

  // Decoded from the next control value so it lands with the write
  always_comb begin
    current_d = drive_current(control_d[lpsc_pkg::CTRL_DRIVE_LSB +: 2], config_d);
    prox_gain_select_d = prox_gain(control_d[lpsc_pkg::CTRL_PROX_GAIN_SELECT_LSB +: 2]);
    light_gain_select_d = light_gain(control_d[lpsc_pkg::CTRL_LIGHT_GAIN_SELECT_LSB +: 2]);
  end

  always_comb begin
    // Set wins over clear on prox valid; on light valid only when both channels finish in the clear cycle
    prox_valid_d = prox_valid_q;
    if (prox_valid_clear) begin
      prox_valid_d = 1'b0;
    end
    if (prox_done) begin
      prox_valid_d = 1'b1;
    end
  end

  always_comb begin
    // Channels may finish in either order; both must be seen
    light0_seen_d = light0_seen_q | light0_done;
    light1_seen_d = light1_seen_q | light1_done;
    light_valid_d = light_valid_q;
    if (light_valid_clear) begin
      light_valid_d = 1'b0;
      light0_seen_d = light0_done;
      light1_seen_d = light1_done;
    end
    if (light0_seen_d && light1_seen_d) begin
      light_valid_d = 1'b1;
      light0_seen_d = 1'b0;
      light1_seen_d = 1'b0;
    end
  end

  always_comb begin
    shadow0_d = shadow0_q;
    shadow1_d = shadow1_q;
    shadowp_d = shadowp_q;
    rd_data_d = rd_data_q;
    rd_valid_d = reg_rd_en;
    if (reg_rd_en) begin
      if (reg_addr == lpsc_pkg::ADDR_ANALOG_CONTROL) begin
        rd_data_d = control_q;
      end else if (reg_addr == lpsc_pkg::ADDR_CONFIG) begin
        rd_data_d = {7'h00, config_q};
      end else if (reg_addr == lpsc_pkg::ADDR_PART_IDENTITY) begin
        rd_data_d = PART_IDENTITY;
      end else if (reg_addr == lpsc_pkg::ADDR_DEVICE_STATUS) begin
        rd_data_d = status_byte;
      end else if (reg_addr == lpsc_pkg::ADDR_LIGHT0_LOW) begin
        rd_data_d = light0_result[7:0];
        shadow0_d = light0_result[15:8];
      end else if (reg_addr == lpsc_pkg::ADDR_LIGHT0_HIGH) begin
        rd_data_d = shadow0_q;
      end else if (reg_addr == lpsc_pkg::ADDR_LIGHT1_LOW) begin
        rd_data_d = light1_result[7:0];
        shadow1_d = light1_result[15:8];
      end else if (reg_addr == lpsc_pkg::ADDR_LIGHT1_HIGH) begin
        rd_data_d = shadow1_q;
      end else if (reg_addr == lpsc_pkg::ADDR_PROX_LOW) begin
        rd_data_d = prox_result[7:0];
        shadowp_d = prox_result[15:8];
      end else if (reg_addr == lpsc_pkg::ADDR_PROX_HIGH) begin
        rd_data_d = shadowp_q;
      end else begin
        rd_data_d = lpsc_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= lpsc_pkg::CONTROL_RESET;
      config_q <= 1'b0;
    end else begin
      control_q <= control_d;
      config_q <= config_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_q <= lpsc_pkg::DRIVE_NORMAL_0;
      prox_gain_select_q <= lpsc_pkg::PROX_GAIN_SELECT_X1;
      light_gain_select_q <= lpsc_pkg::LIGHT_GAIN_SELECT_X1;
    end else begin
      current_q <= current_d;
      prox_gain_select_q <= prox_gain_select_d;
      light_gain_select_q <= light_gain_select_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prox_valid_q <= 1'b0;
    end else begin
      prox_valid_q <= prox_valid_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      light0_seen_q <= 1'b0;
      light1_seen_q <= 1'b0;
      light_valid_q <= 1'b0;
    end else begin
      light0_seen_q <= light0_seen_d;
      light1_seen_q <= light1_seen_d;
      light_valid_q <= light_valid_d;
    end
  end

  // Shadows keep the high byte of the sample whose low byte went out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow0_q <= lpsc_pkg::BYTE_RESET;
      shadow1_q <= lpsc_pkg::BYTE_RESET;
      shadowp_q <= lpsc_pkg::BYTE_RESET;
      rd_data_q <= lpsc_pkg::BYTE_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      shadow0_q <= shadow0_d;
      shadow1_q <= shadow1_d;
      shadowp_q <= shadowp_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign reg_rd_data = rd_data_q;
  assign reg_rd_valid = rd_valid_q;
  assign led_drive_select = control_q[lpsc_pkg::CTRL_DRIVE_LSB +: 2];
  assign prox_diode_select = control_q[lpsc_pkg::CTRL_DIODE_LSB +: 2];
  assign prox_gain_select = control_q[lpsc_pkg::CTRL_PROX_GAIN_SELECT_LSB +: 2];
  assign light_gain_select = control_q[lpsc_pkg::CTRL_LIGHT_GAIN_SELECT_LSB +: 2];
  assign reduced_drive_bit = config_q;
  assign led_current_tenth_ma = current_q;
  assign prox_gain_mult = prox_gain_select_q;
  assign light_gain_mult = light_gain_select_q;
  // High only while the diode field holds the legal DIODE_CH1 code
  assign prox_diode_legal = (control_q[lpsc_pkg::CTRL_DIODE_LSB +: 2] == lpsc_pkg::DIODE_CH1);

endmodule : lpsc_regs
`default_nettype wire

// ==== dv/lpsc_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpsc_regs_monitor #(
  parameter logic [7:0] PART_IDENTITY = lpsc_pkg::PART_IDENTITY_DEFAULT
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic [15:0] prox_result,
  input wire logic prox_done,
  input wire logic prox_valid_clear,
  input wire logic prox_saturated,
  input wire logic prox_irq,
  input wire logic light_irq,
  input wire logic [1:0] led_drive_select,
  input wire logic [1:0] prox_diode_select,
  input wire logic [1:0] prox_gain_select,
  input wire logic [1:0] light_gain_select,
  input wire logic [3:0] prox_gain_mult,
  input wire logic prox_diode_legal
);
  logic [7:0] prox_high;
  logic rd_ctl, wr_ctl, rd_stat;
  assign prox_high = prox_result[15:8];
  assign wr_ctl = reg_wr_en && reg_addr == lpsc_pkg::ADDR_ANALOG_CONTROL;
  assign rd_ctl = reg_rd_en && reg_addr == lpsc_pkg::ADDR_ANALOG_CONTROL;
  assign rd_stat = reg_rd_en && reg_addr == lpsc_pkg::ADDR_DEVICE_STATUS;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  a_rd_valid_follows: assert property (1'b1 |=> reg_rd_valid == $past(reg_rd_en))
    else $error("read valid off");
  a_id_read_only: assert property (reg_rd_en && reg_addr == lpsc_pkg::ADDR_PART_IDENTITY
    |=> reg_rd_data == PART_IDENTITY) else $error("identity byte off");
  a_status_live_bits: assert property (rd_stat |=> reg_rd_data[7:2] ==
    {1'b0, $past(prox_saturated), $past(prox_irq), $past(light_irq), 2'b00}) else $error("status bits off");
  a_prox_valid_set: assert property (prox_done ##1 !prox_valid_clear ##1 rd_stat |=> reg_rd_data[1])
    else $error("prox valid not set");
  a_ctrl_write_back: assert property (wr_ctl ##1 !wr_ctl ##1 rd_ctl |=> reg_rd_data == $past(reg_wr_data, 3))
    else $error("control readback off");
  a_ctrl_fields_out: assert property (wr_ctl |=>
    {led_drive_select, prox_diode_select, prox_gain_select, light_gain_select} == $past(reg_wr_data))
    else $error("control fields off");
  a_gain_diode_decode: assert property (wr_ctl |=> prox_gain_mult == (4'h1 << prox_gain_select) &&
    prox_diode_legal == (prox_diode_select == lpsc_pkg::DIODE_CH1)) else $error("decode off");
  a_prox_shadow_pair: assert property (reg_rd_en && reg_addr == lpsc_pkg::ADDR_PROX_LOW ##1
    reg_rd_en && reg_addr == lpsc_pkg::ADDR_PROX_HIGH |=> reg_rd_data == $past(prox_high, 2))
    else $error("prox shadow off");
endmodule // lpsc_regs_monitor
bind lpsc_regs lpsc_regs_monitor #(.PART_IDENTITY(PART_IDENTITY)) lpsc_regs_monitor_inst (.core_clk, .resetn,
  .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid, .prox_result, .prox_done,
  .prox_saturated, .prox_irq, .light_irq, .led_drive_select, .prox_diode_select, .prox_gain_select,
  .light_gain_select, .prox_gain_mult, .prox_diode_legal, .prox_valid_clear);
`default_nettype wire

// ==== dv/lpsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpsc_host_model (
  input wire logic core_clk,
  output var logic [7:0] reg_addr = 8'h00,
  output var logic reg_wr_en = 1'b0,
  output var logic [7:0] reg_wr_data = 8'h00,
  output var logic reg_rd_en = 1'b0,
  input wire logic [7:0] reg_rd_data
);
  // n bytes from a upward, low first; last byte read ends in d[15:8]
  task automatic xfer(input logic [7:0] a, input int n, input logic we, input logic [7:0] wd,
    output logic [15:0] d);
    d = 16'h0000;
    for (int i = 0; i <= n; i++) begin
      @(negedge core_clk);
      if (i > 0) d = {reg_rd_data, d[15:8]};
      reg_rd_en = (i < n) && !we;
      reg_wr_en = (i < n) && we;
      reg_wr_data = (i < n) ? wd : ~wd;
      reg_addr = (i < n) ? a + 8'(i) : ~a;
    end
  endtask
endmodule // lpsc_host_model
`default_nettype wire

// ==== dv/light_prox_sensor_ctrl_status_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module light_prox_sensor_ctrl_status_regs_tb;
  localparam logic [10:0] CUR [8] = '{11'h3e8, 11'h1f4, 11'h0fa, 11'h07d, 11'h06f, 11'h038, 11'h01c, 11'h00e};
  localparam logic [6:0] LGM [4] = '{7'h01, 7'h08, 7'h10, 7'h78};
  localparam logic [7:0] LOWS [3] = '{lpsc_pkg::ADDR_LIGHT0_LOW, lpsc_pkg::ADDR_LIGHT1_LOW, lpsc_pkg::ADDR_PROX_LOW};
  localparam logic [7:0] STAT = lpsc_pkg::ADDR_DEVICE_STATUS;
  localparam logic [7:0] CTL = lpsc_pkg::ADDR_ANALOG_CONTROL;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, rdb, legal;
  logic [15:0] res [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] ex, d;
  logic [2:0] done = 3'h0;
  logic [2:0] irq = 3'h0;
  logic [1:0] clr = 2'h0;
  logic [1:0] drv, dio, pgs, lgs;
  logic [10:0] cur;
  logic [3:0] pgm;
  logic [6:0] lgm;
  int err_count = 0;
  int cmp_count = 0;
  always #50 core_clk = ~core_clk;
  lpsc_host_model lpsc_host_model_inst (.core_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data);
  lpsc_regs lpsc_regs_inst (.core_clk, .resetn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
    .reg_rd_valid, .light0_result(res[0]), .light1_result(res[1]), .prox_result(res[2]), .light0_done(done[0]),
    .light1_done(done[1]), .prox_done(done[2]), .light_valid_clear(clr[0]), .prox_valid_clear(clr[1]),
    .prox_saturated(irq[2]), .prox_irq(irq[1]), .light_irq(irq[0]), .led_drive_select(drv),
    .prox_diode_select(dio), .prox_gain_select(pgs), .light_gain_select(lgs), .reduced_drive_bit(rdb),
    .led_current_tenth_ma(cur), .prox_gain_mult(pgm), .light_gain_mult(lgm), .prox_diode_legal(legal));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    lpsc_host_model_inst.xfer(a, 1, 1'b1, x, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    lpsc_host_model_inst.xfer(a, 1, 1'b0, 8'h00, d);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d[15:8]});
  endtask
  task automatic tick(input logic [2:0] dn, input logic [1:0] cl);
    done = dn;
    clr = cl;
    @(negedge core_clk);
    done = 3'h0;
    clr = 2'h0;
  endtask
  task automatic summarize;
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(CTL, lpsc_pkg::CONTROL_RESET);
    wr(lpsc_pkg::ADDR_PART_IDENTITY, 8'ha5);
    wr(STAT, 8'hff);
    rdc(lpsc_pkg::ADDR_PART_IDENTITY, lpsc_pkg::PART_IDENTITY_DEFAULT);
    rdc(8'h40, lpsc_pkg::UNMAPPED_READ);
    for (int r = 0; r < 2; r++) begin
      wr(lpsc_pkg::ADDR_CONFIG, 8'(r));
      for (int c = 0; c < 4; c++) begin
        v = {c[1:0], lpsc_pkg::DIODE_CH1, c[1:0], 2'(3 - c)};
        wr(CTL, v);
        rdc(CTL, v);
        chk("led current", 16'(CUR[r * 4 + c]), 16'(cur));
        chk("prox gain", 16'(4'h1 << c), 16'(pgm));
        chk("light gain", 16'(LGM[3 - c]), 16'(lgm));
        chk("diode legal", 16'h0001, 16'(legal));
        chk("control fields", 16'(v), 16'({drv, dio, pgs, lgs}));
        chk("reduced drive", 16'(r), 16'(rdb));
      end
    end
    wr(CTL, 8'h00);
    chk("diode legal", 16'h0000, 16'(legal));
    irq = 3'h5;
    rdc(STAT, 8'h50);
    irq = 3'h2;
    rdc(STAT, 8'h20);
    irq = 3'h0;
    tick(3'h4, 2'h0);
    rdc(STAT, 8'h02);
    tick(3'h1, 2'h0);
    rdc(STAT, 8'h02);
    tick(3'h2, 2'h0);
    rdc(STAT, 8'h03);
    tick(3'h0, 2'h3);
    rdc(STAT, 8'h00);
    tick(3'h7, 2'h3);
    rdc(STAT, 8'h03);
    for (int k = 0; k < 3; k++) begin
      res[k] = 16'h9c3a + 16'(k) * 16'h0202;
      ex = res[k];
      fork
        lpsc_host_model_inst.xfer(LOWS[k], 2, 1'b0, 8'h00, d);
        begin
          repeat (2) @(negedge core_clk);
          res[k] = ~res[k];
        end
      join
      chk("result pair", ex, d);
      rdc(LOWS[k] + 8'h01, ex[15:8]);
    end
    summarize();
  end
endmodule // light_prox_sensor_ctrl_status_regs_tb
`default_nettype wire
